// File: logic/nvm_pkg.sv
// Constants, register map and state types for the nonvolatile access block.
package nvm_pkg;

	// Clock and write cycle timing.
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned WRITE_TIME_NS = 4000;
	localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Pointer and memory geometry.
	localparam int PTR_W       = 22;
	localparam int LOW_W       = 21;
	localparam int BLK_BITS    = 5;
	localparam int ERASE_BITS  = 6;
	localparam int PROG_AW     = 12;
	localparam int EE_AW       = 8;
	localparam int BLOCK_BYTES = 32;
	localparam int ERASE_BYTES = 64;

	// Register byte offsets on the bus.
	localparam logic [7:0] OFF_LATCH = 8'h00;
	localparam logic [7:0] OFF_PTRL  = 8'h04;
	localparam logic [7:0] OFF_PTRH  = 8'h08;
	localparam logic [7:0] OFF_PTRU  = 8'h0c;
	localparam logic [7:0] OFF_TCMD  = 8'h10;
	localparam logic [7:0] OFF_EADR  = 8'h14;
	localparam logic [7:0] OFF_EDAT  = 8'h18;
	localparam logic [7:0] OFF_ECTL  = 8'h1c;
	localparam logic [7:0] OFF_UNLK  = 8'h20;
	localparam logic [7:0] OFF_FLAG  = 8'h24;

	// Field positions.
	localparam int CTL_RD    = 0;
	localparam int CTL_WR    = 1;
	localparam int CTL_WRITE_ENABLE_BIT  = 2;
	localparam int CTL_ERASE = 4;
	localparam int CTL_PGM   = 7;
	localparam int CMD_READ  = 0;
	localparam int CMD_WRITE = 1;
	localparam int CMD_MODE  = 2;
	localparam int CMD_BUSY  = 7;
	localparam int FLG_DONE  = 0;
	localparam int FLG_IE    = 4;

	// Values after reset and fixed data values.
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [7:0] ERASED     = 8'hff;
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Pointer update modes, in the order of their command codes.
	typedef enum logic [1:0] {NVM_NOCHG, NVM_POSTINC, NVM_POSTDEC, NVM_PREINC} nvm_mode_t;
	// Table operation sequencer, write engine and unlock sequencer states.
	typedef enum logic [1:0] {TB_IDLE, TB_ACCESS, TB_FINISH} nvm_tb_t;
	typedef enum logic [1:0] {WE_IDLE, WE_COPY, WE_TIME} nvm_we_t;
	typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_ARMED} nvm_ul_t;

endpackage

// File: logic/nvm_mem.sv
// Byte-wide memory with one write port and a registered read port.
`timescale 1ns/1ps
module nvm_mem #(
	parameter int AW = 8
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);
	// Storage array; contents have no reset, as in a real array.
	logic [7:0] mem_array [0:(1<<AW)-1];

	// Write port.
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem_array[wr_addr] <= wr_data;
	end

	// Read data come out of a register, one cycle after the address.
	always_ff @(posedge clk)
	begin
		if (!resetn)
			rd_data <= nvm_pkg::RST_BYTE;
		else
			rd_data <= mem_array[rd_addr];
	end
endmodule

// File: logic/nvm_unlock.sv
// Unlock key sequencer that arms one write start.
`timescale 1ns/1ps
module nvm_unlock (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       key_wr,
	input  wire logic [7:0] key_data,
	input  wire logic       flush,
	output logic            armed
);
	nvm_pkg::nvm_ul_t state_reg;   // Progress through the key sequence.
	nvm_pkg::nvm_ul_t state_next;  // Next progress value.

	// Any write that breaks the sequence drops back to the start.
	always_comb
	begin
		state_next = state_reg;
		if (flush)
			state_next = nvm_pkg::UL_IDLE;
		else if (key_wr)
		begin
			case (state_reg)
				nvm_pkg::UL_IDLE:
					state_next = (key_data == nvm_pkg::KEY_FIRST) ? nvm_pkg::UL_HALF
						: nvm_pkg::UL_IDLE;
				nvm_pkg::UL_HALF:
					state_next = (key_data == nvm_pkg::KEY_SECOND) ? nvm_pkg::UL_ARMED
						: nvm_pkg::UL_IDLE;
				default:
					state_next = nvm_pkg::UL_IDLE;
			endcase
		end
	end

	// State register.
	always_ff @(posedge clk)
	begin
		if (!resetn)
			state_reg <= nvm_pkg::UL_IDLE;
		else
			state_reg <= state_next;
	end

	assign armed = (state_reg == nvm_pkg::UL_ARMED);
endmodule

// File: logic/nvm_access.sv
// Program memory table access and data EEPROM access behind an AXI4-Lite slave.
// Behaviour
// - Pointer is upper, high, low bytes joined.
// - Low 21 bits bytes; top bit selects config.
// - Pointer steps touch only low 21 bits.
// - Four pointer modes: none, post-inc, post-dec, pre-inc.
// - Table read loads addressed byte into latch.
// - Table write fills holding byte by low bits.
// - Flash write copies holding block, offset ignored.
// - Erase clears 64-byte block, low six ignored.
// - Latch is an 8-bit transfer register.
// - EEPROM read data ready next cycle.
// - Data register holds until read or write.
// - Write starts only after 55h, AAh, start.
// - Start bit blocked while write enable clear.
// - Enable and start not set together.
// - Hardware never clears write enable.
// - Control, address, data locked during write.
// - At end, start bit clears, flag sets.
// - Completion flag stays until software clears.
// - Enable bit gates completion flag interrupt.
`timescale 1ns/1ps
module nvm_access (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             write_complete_irq,
	output logic             nvm_busy
);
	// Identification bytes seen in the configuration space; the values are arbitrary.
	localparam logic [7:0] DEVICE_ID_LO = 8'h5a;
	localparam logic [7:0] DEVICE_ID_HI = 8'h3c;

	// True when a bus address selects the given register offset.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr[7:2] == off[7:2]);
	endfunction

	// True when a bus address selects any implemented register.
	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr[7:2] <= nvm_pkg::OFF_FLAG[7:2]);
	endfunction

	// Configuration space byte: two identity bytes, the rest reads erased.
	function automatic logic [7:0] cfg_byte(input logic [3:0] idx);
		cfg_byte = (idx == 4'he) ? DEVICE_ID_LO : (idx == 4'hf) ? DEVICE_ID_HI
			: nvm_pkg::ERASED;
	endfunction

	// Bus write channel holding registers.
	logic        aw_hold_reg;   // A write address has been taken.
	logic [7:0]  aw_addr_reg;   // The taken write address.
	logic        w_hold_reg;    // Write data have been taken.
	logic [7:0]  w_data_reg;    // Low byte of the taken write data.
	logic        w_lane_reg;    // Low byte lane strobe of the taken data.
	logic        awready_reg;   // Write address ready.
	logic        wready_reg;    // Write data ready.
	logic        bvalid_reg;    // Write response valid.
	logic [1:0]  bresp_reg;     // Write response code.
	logic        arready_reg;   // Read address ready.
	logic        rvalid_reg;    // Read data valid.
	logic [31:0] rdata_reg;     // Read data word.
	logic [1:0]  rresp_reg;     // Read response code.

	// Block state registers.
	logic [7:0]             latch_reg;    // Table data latch.
	logic [nvm_pkg::PTR_W-1:0] ptr_reg;  // Program memory pointer.
	logic [7:0]             ee_addr_reg;  // EEPROM address register.
	logic [7:0]             ee_data_reg;  // EEPROM data register.
	logic                   pgm_reg;      // Program memory select.
	logic                   erase_reg;    // Erase rather than program a flash block.
	logic                   write_enable_bit_reg;     // Write enable bit.
	logic                   wr_reg;       // Write start bit, high during the cycle.
	logic                   rd_reg;       // Read start bit, high for one cycle.
	logic                   done_reg;     // Write complete flag.
	logic                   ie_reg;       // Write complete interrupt enable.
	logic                   irq_reg;      // Gated interrupt output.
	logic                   busy_reg;     // Write engine busy output.
	nvm_pkg::nvm_tb_t       tb_state_reg; // Table operation sequencer.
	logic                   tb_is_wr_reg; // Current table operation is a write.
	nvm_pkg::nvm_mode_t     tb_mode_reg;  // Pointer mode of the current operation.
	nvm_pkg::nvm_we_t       we_state_reg; // Write engine state.
	logic [6:0]             idx_reg;      // Byte index while copying or erasing.
	logic [7:0]             wait_reg;     // Remaining write timer cycles.

	// Memory read data and the unlock state.
	logic [7:0] flash_rdata;  // Program flash byte at the pointer.
	logic [7:0] hold_rdata;   // Holding register byte at the copy index.
	logic [7:0] ee_rdata;     // EEPROM byte at the address register.
	logic       armed;        // Unlock sequence completed.

	// Bus handshakes and the register write strobe.
	wire aw_take  = s_axi_awvalid && awready_reg;
	wire w_take   = s_axi_wvalid && wready_reg;
	wire commit   = aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire ar_take  = s_axi_arvalid && arready_reg;
	wire reg_wr   = commit && w_lane_reg;
	wire we_busy  = (we_state_reg != nvm_pkg::WE_IDLE);
	wire tb_busy  = (tb_state_reg != nvm_pkg::TB_IDLE);

	// Decoded register writes; locked registers ignore writes during a cycle.
	wire wr_latch = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_LATCH);
	wire wr_ptrl  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_PTRL);
	wire wr_ptrh  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_PTRH);
	wire wr_ptru  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_PTRU);
	wire wr_tcmd  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_TCMD) && !tb_busy;
	wire wr_eadr  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_EADR) && !we_busy;
	wire wr_edat  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_EDAT) && !we_busy;
	wire wr_ectl  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_ECTL) && !we_busy;
	wire wr_unlk  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_UNLK);
	wire wr_flag  = reg_wr && hit(aw_addr_reg, nvm_pkg::OFF_FLAG);

	// Start needs the key sequence and an enable that was already set.
	wire start    = wr_ectl && w_data_reg[nvm_pkg::CTL_WR] && write_enable_bit_reg && armed;
	wire rd_start = wr_ectl && w_data_reg[nvm_pkg::CTL_RD]
		&& !w_data_reg[nvm_pkg::CTL_PGM] && !w_data_reg[nvm_pkg::CTL_WR];
	wire start_pgm   = w_data_reg[nvm_pkg::CTL_PGM];
	wire [6:0] count = erase_reg ? 7'(nvm_pkg::ERASE_BYTES) : 7'(nvm_pkg::BLOCK_BYTES);

	// Pointer arithmetic keeps the top bit out of every step.
	wire [nvm_pkg::PTR_W-1:0] ptr_inc = {ptr_reg[nvm_pkg::LOW_W], ptr_reg[nvm_pkg::LOW_W-1:0]
		+ 21'h000001};
	wire [nvm_pkg::PTR_W-1:0] ptr_dec = {ptr_reg[nvm_pkg::LOW_W], ptr_reg[nvm_pkg::LOW_W-1:0]
		- 21'h000001};
	wire [nvm_pkg::PTR_W-1:0] ptr_sw = {wr_ptru ? w_data_reg[5:0] : ptr_reg[21:16],
		wr_ptrh ? w_data_reg : ptr_reg[15:8], wr_ptrl ? w_data_reg : ptr_reg[7:0]};

	// Table read result: the top pointer bit redirects to the configuration space.
	wire [7:0] tbl_byte = ptr_reg[nvm_pkg::LOW_W] ? cfg_byte(ptr_reg[3:0]) : flash_rdata;

	// Holding register write: only the block offset bits address it.
	wire hold_we = (tb_state_reg == nvm_pkg::TB_ACCESS) && tb_is_wr_reg;
	wire [4:0] hold_waddr = ptr_reg[nvm_pkg::BLK_BITS-1:0];

	// Flash block writes lag the holding read by one cycle.
	wire [6:0] flash_off = idx_reg - 7'h01;
	wire flash_we = (we_state_reg == nvm_pkg::WE_COPY) && (idx_reg != 7'h00)
		&& !ptr_reg[nvm_pkg::LOW_W];
	wire [nvm_pkg::PROG_AW-1:0] flash_waddr = erase_reg
		? {ptr_reg[nvm_pkg::PROG_AW-1:nvm_pkg::ERASE_BITS], flash_off[5:0]}
		: {ptr_reg[nvm_pkg::PROG_AW-1:nvm_pkg::BLK_BITS], flash_off[4:0]};
	wire [7:0] flash_wdata = erase_reg ? nvm_pkg::ERASED : hold_rdata;
	wire ee_we = start && !start_pgm;

	// Register read multiplexer; reserved bits read as zero.
	wire [7:0] rd_byte =
		hit(s_axi_araddr, nvm_pkg::OFF_LATCH) ? latch_reg :
		hit(s_axi_araddr, nvm_pkg::OFF_PTRL)  ? ptr_reg[7:0] :
		hit(s_axi_araddr, nvm_pkg::OFF_PTRH)  ? ptr_reg[15:8] :
		hit(s_axi_araddr, nvm_pkg::OFF_PTRU)  ? {2'h0, ptr_reg[21:16]} :
		hit(s_axi_araddr, nvm_pkg::OFF_TCMD)  ? {tb_busy, 7'h00} :
		hit(s_axi_araddr, nvm_pkg::OFF_EADR)  ? ee_addr_reg :
		hit(s_axi_araddr, nvm_pkg::OFF_EDAT)  ? ee_data_reg :
		hit(s_axi_araddr, nvm_pkg::OFF_ECTL)  ? {pgm_reg, 2'h0, erase_reg, 1'b0, write_enable_bit_reg,
			wr_reg, rd_reg} :
		hit(s_axi_araddr, nvm_pkg::OFF_FLAG)  ? {3'h0, ie_reg, 3'h0, done_reg} : 8'h00;

	// Memories: program flash, holding block and data EEPROM.
	nvm_mem #(.AW(nvm_pkg::PROG_AW)) u_flash (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (flash_we),
		.wr_addr (flash_waddr),
		.wr_data (flash_wdata),
		.rd_addr (ptr_reg[nvm_pkg::PROG_AW-1:0]),
		.rd_data (flash_rdata)
	);
	nvm_mem #(.AW(nvm_pkg::BLK_BITS)) u_hold (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (hold_we),
		.wr_addr (hold_waddr),
		.wr_data (latch_reg),
		.rd_addr (idx_reg[4:0]),
		.rd_data (hold_rdata)
	);
	nvm_mem #(.AW(nvm_pkg::EE_AW)) u_eeprom (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (ee_we),
		.wr_addr (ee_addr_reg),
		.wr_data (ee_data_reg),
		.rd_addr (ee_addr_reg),
		.rd_data (ee_rdata)
	);

	// A control write that does not start a cycle also spoils the key sequence.
	nvm_unlock u_unlock (
		.clk      (clk),
		.resetn   (resetn),
		.key_wr   (wr_unlk),
		.key_data (w_data_reg),
		.flush    (reg_wr && !wr_unlk),
		.armed    (armed)
	);

	// Write address and data are taken in either order; the response follows both.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= nvm_pkg::RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
		end
		else
		begin
			aw_hold_reg <= (aw_hold_reg && !commit) || aw_take;
			w_hold_reg  <= (w_hold_reg && !commit) || w_take;
			awready_reg <= !((aw_hold_reg && !commit) || aw_take);
			wready_reg  <= !((w_hold_reg && !commit) || w_take);
			if (aw_take)
				aw_addr_reg <= s_axi_awaddr;
			if (w_take)
			begin
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (commit)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= mapped(aw_addr_reg) ? nvm_pkg::RESP_OKAY : nvm_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// Read channel: data are sampled when the address is taken.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= nvm_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= {24'h000000, rd_byte};
			rresp_reg   <= mapped(s_axi_araddr) ? nvm_pkg::RESP_OKAY : nvm_pkg::RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
		else
			arready_reg <= !rvalid_reg;
	end

	// Table sequencer: pre-step, access, then latch capture and post-step.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			tb_state_reg <= nvm_pkg::TB_IDLE;
			tb_is_wr_reg <= 1'b0;
			tb_mode_reg  <= nvm_pkg::NVM_NOCHG;
			ptr_reg      <= 22'h000000;
			latch_reg    <= nvm_pkg::RST_BYTE;
		end
		else
		begin
			case (tb_state_reg)
				nvm_pkg::TB_IDLE:
				begin
					ptr_reg <= ptr_sw;
					if (wr_latch)
						latch_reg <= w_data_reg;
					if (wr_tcmd && (w_data_reg[nvm_pkg::CMD_READ] ||
						w_data_reg[nvm_pkg::CMD_WRITE]))
					begin
						tb_state_reg <= nvm_pkg::TB_ACCESS;
						tb_is_wr_reg <= w_data_reg[nvm_pkg::CMD_WRITE];
						tb_mode_reg  <= nvm_pkg::nvm_mode_t'(w_data_reg[3:2]);
						if (nvm_pkg::nvm_mode_t'(w_data_reg[3:2]) == nvm_pkg::NVM_PREINC)
							ptr_reg <= ptr_inc;
					end
				end
				nvm_pkg::TB_ACCESS:
					tb_state_reg <= nvm_pkg::TB_FINISH;
				nvm_pkg::TB_FINISH:
				begin
					tb_state_reg <= nvm_pkg::TB_IDLE;
					if (!tb_is_wr_reg)
						latch_reg <= tbl_byte;
					if (tb_mode_reg == nvm_pkg::NVM_POSTINC)
						ptr_reg <= ptr_inc;
					else if (tb_mode_reg == nvm_pkg::NVM_POSTDEC)
						ptr_reg <= ptr_dec;
				end
				default:
					tb_state_reg <= nvm_pkg::TB_IDLE;
			endcase
		end
	end

	// EEPROM registers and the control bits that software owns.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ee_addr_reg <= nvm_pkg::RST_BYTE;
			ee_data_reg <= nvm_pkg::RST_BYTE;
			pgm_reg     <= 1'b0;
			erase_reg   <= 1'b0;
			write_enable_bit_reg    <= 1'b0;
			rd_reg      <= 1'b0;
			ie_reg      <= 1'b0;
		end
		else
		begin
			if (wr_eadr)
				ee_addr_reg <= w_data_reg;
			if (rd_reg)
				ee_data_reg <= ee_rdata;
			else if (wr_edat)
				ee_data_reg <= w_data_reg;
			if (wr_ectl)
			begin
				pgm_reg   <= w_data_reg[nvm_pkg::CTL_PGM];
				erase_reg <= w_data_reg[nvm_pkg::CTL_ERASE];
				write_enable_bit_reg  <= w_data_reg[nvm_pkg::CTL_WRITE_ENABLE_BIT];
			end
			rd_reg <= rd_start;
			if (wr_flag)
				ie_reg <= w_data_reg[nvm_pkg::FLG_IE];
		end
	end

	// Write engine: for program memory, copy or erase a flash block; then run the write timer.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			we_state_reg <= nvm_pkg::WE_IDLE;
			wr_reg       <= 1'b0;
			idx_reg      <= 7'h00;
			wait_reg     <= 8'h00;
		end
		else
		begin
			case (we_state_reg)
				nvm_pkg::WE_IDLE:
					if (start)
					begin
						wr_reg       <= 1'b1;
						idx_reg      <= 7'h00;
						wait_reg     <= 8'(nvm_pkg::WRITE_CYCLES - 1);
						we_state_reg <= start_pgm ? nvm_pkg::WE_COPY : nvm_pkg::WE_TIME;
					end
				nvm_pkg::WE_COPY:
				begin
					idx_reg <= idx_reg + 7'h01;
					if (idx_reg == count)
						we_state_reg <= nvm_pkg::WE_TIME;
				end
				nvm_pkg::WE_TIME:
					if (wait_reg == 8'h00)
					begin
						wr_reg       <= 1'b0;
						we_state_reg <= nvm_pkg::WE_IDLE;
					end
					else
						wait_reg <= wait_reg - 8'h01;
				default:
					we_state_reg <= nvm_pkg::WE_IDLE;
			endcase
		end
	end

	// Completion flag: a finishing cycle wins over a software clear.
	wire finish = (we_state_reg == nvm_pkg::WE_TIME) && (wait_reg == 8'h00);
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			done_reg <= 1'b0;
			irq_reg  <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			if (finish)
				done_reg <= 1'b1;
			else if (wr_flag)
				done_reg <= w_data_reg[nvm_pkg::FLG_DONE];
			irq_reg  <= done_reg && ie_reg;
			busy_reg <= we_busy;
		end
	end

	assign s_axi_awready      = awready_reg;
	assign s_axi_wready       = wready_reg;
	assign s_axi_bvalid       = bvalid_reg;
	assign s_axi_bresp        = bresp_reg;
	assign s_axi_arready      = arready_reg;
	assign s_axi_rvalid       = rvalid_reg;
	assign s_axi_rdata        = rdata_reg;
	assign s_axi_rresp        = rresp_reg;
	assign write_complete_irq = irq_reg;
	assign nvm_busy           = busy_reg;

	// Checks on the behaviour above.
	chk_ptr_top_kept: assert property (@(posedge clk) disable iff (!resetn)
		(tb_state_reg == nvm_pkg::TB_FINISH) |=> ptr_reg[21] == $past(ptr_reg[21]))
		else $error("pointer step changed the top bit");
	chk_rd_self_clear: assert property (@(posedge clk) disable iff (!resetn)
		rd_reg |=> !rd_reg)
		else $error("read bit did not clear");
	chk_ee_read_next: assert property (@(posedge clk) disable iff (!resetn)
		rd_reg |=> ee_data_reg == $past(ee_rdata))
		else $error("read data not loaded next cycle");
	chk_wr_needs_write_enable_bit: assert property (@(posedge clk) disable iff (!resetn)
		$rose(wr_reg) |-> $past(write_enable_bit_reg))
		else $error("write started without enable");
	chk_wr_needs_key: assert property (@(posedge clk) disable iff (!resetn)
		$rose(wr_reg) |-> $past(armed) && $past(wr_ectl))
		else $error("write started without unlock");
	chk_write_enable_bit_sw_only: assert property (@(posedge clk) disable iff (!resetn)
		(write_enable_bit_reg != $past(write_enable_bit_reg)) |-> $past(wr_ectl))
		else $error("write enable changed by hardware");
	chk_lock_regs: assert property (@(posedge clk) disable iff (!resetn)
		we_busy |=> $stable(ee_addr_reg) && $stable(write_enable_bit_reg))
		else $error("locked register changed during write");
	chk_done_at_end: assert property (@(posedge clk) disable iff (!resetn)
		$fell(wr_reg) |-> done_reg && !we_busy)
		else $error("flag not set at write end");
	chk_done_sticky: assert property (@(posedge clk) disable iff (!resetn)
		done_reg && !wr_flag |=> done_reg)
		else $error("completion flag cleared by hardware");
	chk_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
		##1 irq_reg == ($past(done_reg) && $past(ie_reg)))
		else $error("interrupt not gated by enable");
endmodule

// File: tb/nvm_cpu_model.sv
// CPU core model: AXI4-Lite master issuing register stores and loads.
`timescale 1ns/1ps
module nvm_cpu_model (
	input  wire logic        clk, s_axi_awready, s_axi_wready, s_axi_bvalid,
	input  wire logic        s_axi_arready, s_axi_rvalid,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic [1:0]  s_axi_bresp,
	output logic [7:0]       s_axi_awaddr, s_axi_araddr,
	output logic [31:0]      s_axi_wdata,
	output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready,
	output logic             s_axi_arvalid, s_axi_rready
);
	initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
	initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
	// Response code of the last write, taken at the edge that sees bvalid high.
	logic [1:0] bresp_seen = 2'h0;
	// Payloads are inverted once taken, so stale values never pass for live ones.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clk);
			if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, 24'hffffff, ~d};
		end while (!s_axi_bvalid);
		bresp_seen = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do
		begin
			@(posedge clk);
			if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
		end while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
endmodule

// File: tb/test_nvm_access.sv
// Register-level regression of the nonvolatile access block.
`timescale 1ns/1ps
module test_nvm_access;
	logic        clk = 1'b0, resetn = 1'b0, write_complete_irq, nvm_busy;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          n_errors = 0, cmp_count = 0;
	always #20 clk = ~clk;
	nvm_access dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_complete_irq, .nvm_busy);
	nvm_cpu_model cpu (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		n_errors += int'(got !== exp);
		if (got !== exp) $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
	endtask
	task automatic r(input logic [7:0] a, input logic [31:0] e);
		cpu.rd(a, rv, rs);
		chk(rv, e);
	endtask
	task automatic tc(input logic [7:0] c);
		hold();
		cpu.wr(8'h10, c);
		repeat (4) @(posedge clk);
	endtask
	task automatic go(input logic [7:0] c);
		cpu.wr(8'h20, nvm_pkg::KEY_FIRST);
		cpu.wr(8'h20, nvm_pkg::KEY_SECOND);
		cpu.wr(8'h1c, c);
	endtask
	task automatic hold();
		repeat (3) @(posedge clk);
		repeat (500) if (nvm_busy !== 1'b0) @(posedge clk);
	endtask
	task automatic summarize(input bit late);
		n_errors += int'(late);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial #400000 summarize(1'b1);
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		cpu.wr(8'h0c, 8'h3f);
		cpu.wr(8'h08, 8'hff);
		cpu.wr(8'h04, 8'hff);
		tc(8'h05);
		r(8'h0c, 32'h20);
		tc(8'h09);
		r(8'h0c, 32'h3f);
		tc(8'h0d);
		r(8'h0c, 32'h20);
		r(8'h28, 32'h0);
		chk(32'(rs), 32'(nvm_pkg::RESP_SLVERR));
		cpu.wr(8'h28, 8'h5a);
		chk(32'(cpu.bresp_seen), 32'(nvm_pkg::RESP_SLVERR));
		cpu.wr(8'h0c, 8'h00);
		cpu.wr(8'h04, 8'h43);
		chk(32'(cpu.bresp_seen), 32'(nvm_pkg::RESP_OKAY));
		cpu.wr(8'h00, 8'ha5);
		tc(8'h02);
		cpu.wr(8'h1c, 8'h84);
		go(8'h86);
		tc(8'h01);
		r(8'h00, 32'ha5);
		go(8'h96);
		tc(8'h01);
		r(8'h00, 32'(nvm_pkg::ERASED));
		cpu.wr(8'h1c, 8'h00);
		cpu.wr(8'h24, 8'h00);
		cpu.wr(8'h14, 8'h10);
		cpu.wr(8'h18, 8'h3c);
		go(8'h06);
		cpu.wr(8'h20, nvm_pkg::KEY_FIRST);
		cpu.wr(8'h1c, 8'h06);
		hold();
		r(8'h24, 32'h0);
		r(8'h1c, 32'h04);
		go(8'h06);
		cpu.wr(8'h18, 8'h77);
		chk(32'(nvm_busy), 32'h1);
		hold();
		r(8'h18, 32'h3c);
		r(8'h1c, 32'h04);
		cpu.wr(8'h18, 8'h77);
		r(8'h18, 32'h77);
		cpu.wr(8'h1c, 8'h01);
		r(8'h18, 32'h3c);
		cpu.wr(8'h24, 8'h11);
		r(8'h24, 32'h11);
		chk(32'(write_complete_irq), 32'h1);
		summarize(1'b0);
	end
endmodule
